// ---- rtl/ptbi_pkg.sv ----
// package for the periodic timebase interrupt block
package ptbi_pkg;
   // register bus geometry
   localparam int ADDR_W = 2;
   localparam int DATA_W = 8;

   // register offsets
   localparam logic [ADDR_W-1:0] OFF_CONTROL = 2'h0;
   localparam logic [ADDR_W-1:0] OFF_STATUS  = 2'h1;
   localparam logic [ADDR_W-1:0] OFF_MASK    = 2'h2;

   // timebase_control field positions
   localparam int CTL_PENDING = 7;
   localparam int CTL_RATE_HI = 6;
   localparam int CTL_RATE_LO = 4;
   localparam int CTL_ACK     = 3;
   localparam int CTL_IRQ_EN  = 2;
   localparam int CTL_CHAIN   = 1;

   // status and mask field positions
   localparam int ST_TICK    = 0;
   localparam int ST_OVERRUN = 1;
   localparam int ST_W       = 2;

   // reset values
   localparam logic [2:0]      RATE_RST  = 3'h0;
   localparam logic [ST_W-1:0] MASK_RST  = 2'h0;
   localparam logic [DATA_W-1:0] RD_ZERO = 8'h00;

   // divider chain
   localparam int CHAIN_W = 15;
   localparam int RATE_W  = 3;

   // tap bit per rate code: ratio 2^(k), event on rise of bit k-1
   localparam logic [3:0] TAP_BIT [8] = '{
      4'hE, 4'hC, 4'hA, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2
   };

   // bus request carrier
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } ptbi_req_t;

   // chain activity state
   typedef enum logic [2:0] {
      PTBI_IDLE   = 3'b001,
      PTBI_RUN    = 3'b010,
      PTBI_FROZEN = 3'b100
   } ptbi_state_t;
endpackage

// ---- rtl/ptbi_top.sv ----
// periodic timebase interrupt: divider chain, control register, interrupt
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
// Notes on behaviour
// - the pending flag sets on each rollover at the tap and reads back.
// - the rate code picks divide 32768, 8192, 2048, 128, 64, 32, 16 or 8.
// - the acknowledge bit is write-only and reads as zero.
// - a one written to acknowledge clears the pending flag, a zero does not.
// - the interrupt enable is read/write, reset clear, and routes the flag.
// - the chain enable is read/write, reset clear; off holds it at zero.
// - clearing then setting the chain enable restarts the chain from zero.
// - a rollover with interrupt enable set raises the interrupt request.
// - in wait mode the chain keeps running and the register is unreachable.
// - in stop mode the chain runs only when the oscillator runs in stop.
// - otherwise the chain idles in stop, and the register is unreachable.
// - the first event comes at half a period, later ones at a full period.
// - the chain has fifteen stages of which eight can serve as the tap.

// design notes
// - the tick source is sampled by mclk, which must run far faster than it
// - a rollover and an acknowledge in one cycle leave the flag set
// - turning the chain off keeps a pending flag until it is acknowledged
// - the status register mirrors the flag and adds an overrun event
// - overrun marks a rollover that found the flag still pending
// - mask bit 0 is the interrupt enable seen a second way
// - in stop without the oscillator the chain keeps its count and resumes
// - register access is refused in wait and stop; reads then return zero
// - read data stand for one cycle after the strobe and are zero otherwise
// - the rate code must only change while the chain is off
// - the first rollover after enable comes at half the divide period
// - all later rollovers come a full divide period apart
// - reset clears every enable, the rate code, the chain and both flags
// - the interrupt output is a level, high while an enabled event pends
// - unmapped offsets read zero and ignore writes
// - mask bit 1 routes overrun to the interrupt output
// - a tick that arrives in stop without the oscillator is simply missed
// - the chain counts the tick source only, never mclk itself
// - the rate code has eight taps out of fifteen chain stages
// - the chain clears at once when it is turned off
// - a rate change while counting can give one short or long period
// - the tick source edge is seen two mclk cycles after it happens
// - the pending flag sets on the mclk edge after the counted tick edge
// - a low-power mode never clears the interrupt by itself
module ptbi_top
   import ptbi_pkg::*;
(
   input  wire logic                      mclk,
   input  wire logic                      srst,
   input  wire ptbi_pkg::ptbi_req_t       bus_req,
   output logic [ptbi_pkg::DATA_W-1:0]    bus_rdata,
   input  wire logic                      tick_source_clock,
   input  wire logic                      wait_mode,
   input  wire logic                      stop_mode,
   input  wire logic                      oscillator_run_in_stop,
   output logic                           irq
);
   import ptbi_pkg::*;

   // tick source capture
   logic                 src_meta_q;
   logic                 src_sync_q;
   logic                 src_prev_q;
   logic                 tick_edge;

   // divider chain and tap selection
   logic [CHAIN_W-1:0]   chain_q;
   logic [CHAIN_W-1:0]   tap_mask;
   logic [CHAIN_W-1:0]   half_mask;
   logic [3:0]           tap_bit;
   logic                 tap_hit;
   logic                 chain_live;

   // register bus decode
   logic                 bus_open;
   logic                 wr_ctl;
   logic                 wr_st;
   logic                 wr_mask;
   logic                 ack_ctl;
   logic                 ack_st;
   logic                 ack_clr;
   logic                 ovr_hit;
   logic                 ovr_clr;

   // control and event state
   logic                 tick_pending_flag;
   logic                 overrun_q;
   logic [RATE_W-1:0]    tick_rate_select;
   logic                 tick_irq_enable;
   logic                 tick_chain_enable;
   logic [ST_W-1:0]      mask_q;

   // register views and interrupt terms
   logic [ST_W-1:0]      status;
   logic [DATA_W-1:0]    rdata_q;
   logic [DATA_W-1:0]    rd_mux;
   logic                 irq_tick;
   logic                 irq_ovr;

   // chain activity
   ptbi_state_t          state_q;
   ptbi_state_t          state_d;

   // register access is closed in wait and stop
   assign bus_open = ~wait_mode & ~stop_mode;

   // one write enable per register offset
   assign wr_ctl   = bus_req.wr & bus_open
                   & (bus_req.addr == OFF_CONTROL);
   assign wr_st    = bus_req.wr & bus_open
                   & (bus_req.addr == OFF_STATUS);
   assign wr_mask  = bus_req.wr & bus_open
                   & (bus_req.addr == OFF_MASK);

   // tick source synchroniser and rising edge detect
   always_ff @(posedge mclk) begin
      if (srst) begin
         src_meta_q <= 1'b0;
         src_sync_q <= 1'b0;
         src_prev_q <= 1'b0;
      end else begin
         src_meta_q <= tick_source_clock;
         src_sync_q <= src_meta_q;
         src_prev_q <= src_sync_q;
      end
   end
   // one-cycle pulse on each synchronised rise of the tick source
   assign tick_edge = src_sync_q & ~src_prev_q;

   // chain activity: stopped oscillator freezes the chain in stop
   always_comb begin
      state_d = state_q;
      case (state_q)
         PTBI_IDLE: begin
            if (tick_chain_enable) begin
               state_d = PTBI_RUN;
            end
         end
         PTBI_RUN: begin
            if (!tick_chain_enable) begin
               state_d = PTBI_IDLE;
            end else if (stop_mode && !oscillator_run_in_stop) begin
               state_d = PTBI_FROZEN;
            end
         end
         PTBI_FROZEN: begin
            if (!tick_chain_enable) begin
               state_d = PTBI_IDLE;
            end else if (!stop_mode || oscillator_run_in_stop) begin
               state_d = PTBI_RUN;
            end
         end
         default: begin
            state_d = PTBI_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge mclk) begin
      if (srst) begin
         state_q <= PTBI_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // chain advances only while running; wait mode does not stop it
   // the stop term closes the gap before the state register catches up
   assign chain_live = (state_q == PTBI_RUN) & tick_chain_enable
                     & ~(stop_mode & ~oscillator_run_in_stop);

   // tap selection: the chain bit that rises once per divide period
   assign tap_bit = TAP_BIT[tick_rate_select];

   // per-bit masks: the period field runs up to and including the tap bit,
   // the half-period pattern is all ones just below the tap bit
   for (genvar b = 0; b < CHAIN_W; b++) begin : g_mask
      assign tap_mask[b]  = (4'(b) <= tap_bit);
      assign half_mask[b] = (4'(b) < tap_bit);
   end

   // rollover: the tap bit is about to rise on this tick
   assign tap_hit = chain_live & tick_edge
                  & ((chain_q & tap_mask) == half_mask);

   // fifteen stage divider, held at zero while disabled
   always_ff @(posedge mclk) begin
      if (srst) begin
         chain_q <= '0;
      end else if (!tick_chain_enable) begin
         chain_q <= '0;
      end else if (chain_live && tick_edge) begin
         chain_q <= chain_q + CHAIN_W'(1);
      end
   end

   // control fields written from the bus
   always_ff @(posedge mclk) begin
      if (srst) begin
         tick_rate_select  <= RATE_RST;
         tick_irq_enable   <= 1'b0;
         tick_chain_enable <= 1'b0;
      end else if (wr_ctl) begin
         tick_rate_select  <= bus_req.wdata[CTL_RATE_HI:CTL_RATE_LO];
         tick_irq_enable   <= bus_req.wdata[CTL_IRQ_EN];
         tick_chain_enable <= bus_req.wdata[CTL_CHAIN];
      end else if (wr_mask) begin
         // mask bit 0 is a second view of the interrupt enable
         tick_irq_enable   <= bus_req.wdata[ST_TICK];
      end
   end

   // acknowledge from the control register: a one in the ack bit
   assign ack_ctl = wr_ctl & bus_req.wdata[CTL_ACK];
   // acknowledge from the status register: a one written to the flag
   assign ack_st  = wr_st & bus_req.wdata[ST_TICK];
   // either source clears; a zero written leaves the flag alone
   assign ack_clr = ack_ctl | ack_st;

   // pending flag: a rollover wins over a clear in the same cycle
   always_ff @(posedge mclk) begin
      if (srst) begin
         tick_pending_flag <= 1'b0;
      end else if (tap_hit) begin
         tick_pending_flag <= 1'b1;
      end else if (ack_clr) begin
         tick_pending_flag <= 1'b0;
      end
   end

   // overrun event and its write-one-to-clear strobe
   assign ovr_hit = tap_hit & tick_pending_flag;
   assign ovr_clr = wr_st & bus_req.wdata[ST_OVERRUN];

   // overrun: rollover while the previous one is still pending; set wins
   always_ff @(posedge mclk) begin
      if (srst) begin
         overrun_q <= 1'b0;
      end else if (ovr_hit) begin
         overrun_q <= 1'b1;
      end else if (ovr_clr) begin
         overrun_q <= 1'b0;
      end
   end

   // overrun mask bit; tick mask bit aliases the interrupt enable
   always_ff @(posedge mclk) begin
      if (srst) begin
         mask_q <= MASK_RST;
      end else if (wr_mask) begin
         mask_q <= bus_req.wdata[ST_W-1:0];
      end
   end

   // status view: overrun above the pending flag
   assign status = {overrun_q, tick_pending_flag};

   // tick interrupt term: pending flag passed by the interrupt enable
   assign irq_tick = tick_pending_flag & tick_irq_enable;
   // overrun interrupt term: overrun passed by its mask bit
   assign irq_ovr  = overrun_q & mask_q[ST_OVERRUN];

   // level interrupt while an enabled event is pending; it also wakes stop
   always_comb begin
      irq = irq_tick | irq_ovr;
   end

   // read mux; ack bit and unused bits read zero
   always_comb begin
      rd_mux = RD_ZERO;
      case (bus_req.addr)
         OFF_CONTROL: begin
            // flag, rate and enables; the ack bit always reads zero
            rd_mux[CTL_PENDING]             = tick_pending_flag;
            rd_mux[CTL_RATE_HI:CTL_RATE_LO] = tick_rate_select;
            rd_mux[CTL_ACK]                 = 1'b0;
            rd_mux[CTL_IRQ_EN]              = tick_irq_enable;
            rd_mux[CTL_CHAIN]               = tick_chain_enable;
         end
         OFF_STATUS: begin
            // both sticky events
            rd_mux[ST_W-1:0] = status;
         end
         OFF_MASK: begin
            // overrun mask above the aliased interrupt enable
            rd_mux[ST_W-1:0] = {mask_q[ST_OVERRUN], tick_irq_enable};
         end
         default: begin
            rd_mux = RD_ZERO;
         end
      endcase
   end

   // read data stands one cycle after the strobe only
   always_ff @(posedge mclk) begin
      if (srst) begin
         rdata_q <= RD_ZERO;
      end else if (bus_req.rd && bus_open) begin
         rdata_q <= rd_mux;
      end else begin
         // idle cycles and refused reads return zero
         rdata_q <= RD_ZERO;
      end
   end
   assign bus_rdata = rdata_q;

endmodule // ptbi_top

// ---- tb/ptbi_sva.sv ----
// checker for the periodic timebase interrupt block
`timescale 1ns/1ps
module ptbi_sva
   import ptbi_pkg::*;
(
   input wire logic                  mclk,
   input wire logic                  srst,
   input wire ptbi_pkg::ptbi_req_t   bus_req,
   input wire logic [ptbi_pkg::DATA_W-1:0] bus_rdata,
   input wire logic                  tick_source_clock,
   input wire logic                  wait_mode,
   input wire logic                  stop_mode,
   input wire logic                  oscillator_run_in_stop,
   input wire logic                  irq
);
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   logic       t_q;
   logic [7:0] h_q;
   logic       lp;
   // register access is dropped in either low-power mode
   assign lp = wait_mode | stop_mode;
   // history of tick clock rises over the last eight cycles
   always_ff @(posedge mclk) begin
      t_q <= tick_source_clock;
      h_q <= {h_q[6:0], tick_source_clock & ~t_q};
   end
   sequence s_rd(a); bus_req.rd && !lp && bus_req.addr == a; endsequence
   sequence s_frz; (stop_mode && !oscillator_run_in_stop)[*5]; endsequence
   property p_idle; !$past(bus_req.rd) |-> bus_rdata == 8'h00; endproperty
   a_idle: assert property (p_idle)
      else $error("read data outside its slot");
   property p_lp_rd; $past(bus_req.rd && lp) |-> bus_rdata == 8'h00;
   endproperty
   a_lp_rd: assert property (p_lp_rd)
      else $error("read answered in low power");
   property p_ack0; s_rd(OFF_CONTROL) |=> !bus_rdata[3] && !bus_rdata[0];
   endproperty
   a_ack0: assert property (p_ack0)
      else $error("acknowledge bit read as one");
   property p_pend;
      s_rd(OFF_CONTROL) ##1 (bus_rdata[7] && bus_rdata[2]) |-> $past(irq);
   endproperty
   a_pend: assert property (p_pend)
      else $error("enabled pending flag without interrupt");
   property p_fall; $fell(irq) |-> $past(bus_req.wr && !lp); endproperty
   a_fall: assert property (p_fall)
      else $error("interrupt dropped without a write");
   property p_rise; $rose(irq) |-> $past(bus_req.wr) || (|h_q); endproperty
   a_rise: assert property (p_rise)
      else $error("interrupt rose with no cause");
   property p_frz; s_frz |-> $stable(irq); endproperty
   a_frz: assert property (p_frz)
      else $error("interrupt moved in stop");
   property p_lp_hold; lp |=> !$fell(irq); endproperty
   a_lp_hold: assert property (p_lp_hold)
      else $error("interrupt cleared in low power");
endmodule // ptbi_sva

bind ptbi_top ptbi_sva ptbi_sva_i (.mclk, .srst, .bus_req, .bus_rdata,
   .tick_source_clock, .wait_mode, .stop_mode, .oscillator_run_in_stop, .irq);

// ---- tb/tb_top.sv ----
// self-checking bench for the periodic timebase interrupt block
`timescale 1ns/1ps
module tb_top;
   import ptbi_pkg::*;
   logic       mclk = 0, srst = 1, tck = 0, wm = 0, sm = 0, osc = 0;
   ptbi_req_t  bus_req = '0;
   logic [7:0] bus_rdata, rv;
   logic       irq;
   int         err_count = 0, num_checks = 0, n;
   // 50 ns clock
   always #25 mclk = ~mclk;
   ptbi_top ptbi_top_i (.mclk, .srst, .bus_req, .bus_rdata,
      .tick_source_clock(tck), .wait_mode(wm), .stop_mode(sm),
      .oscillator_run_in_stop(osc), .irq);
   // compare and count
   task automatic chk(string s, logic [7:0] v, logic [7:0] e);
      num_checks++;
      if (v !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", s, e, v);
      end
   endtask
   task automatic ci(string s, logic e);
      chk(s, {7'h00, irq}, {7'h00, e});
   endtask
   // one-cycle bus strobes
   task automatic wr(logic [1:0] a, logic [7:0] d);
      @(posedge mclk) bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge mclk) bus_req.wr <= 1'b0;
      #1;
   endtask
   task automatic rd(logic [1:0] a);
      @(posedge mclk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge mclk) bus_req.rd <= 1'b0;
      #1 rv = bus_rdata;
   endtask
   // tick pulses of sixteen cycles each
   task automatic ticks(int k);
      repeat (k) begin
         @(posedge mclk) tck <= 1'b1;
         repeat (8) @(posedge mclk);
         tck <= 1'b0;
         repeat (7) @(posedge mclk);
         #1;
      end
   endtask
   task automatic wait_irq();
      n = 0;
      while (irq !== 1'b1 && n < 300) begin
         ticks(1);
         n++;
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // watchdog against a hang
   initial begin
      repeat (90000) @(posedge mclk);
      err_count++;
      conclude();
   end
   // main sequence
   initial begin
      repeat (8) @(posedge mclk);
      srst <= 1'b0;
      rd(OFF_CONTROL);
      chk("ctl rst", rv, 8'h00);
      rd(OFF_MASK);
      chk("mask rst", rv, 8'h00);
      for (int r = 0; r < 8; r++) begin
         wr(OFF_CONTROL, {1'b0, r[2:0], 4'hC});
         rd(OFF_CONTROL);
         chk("rate", rv, {1'b0, r[2:0], 4'h4});
      end
      for (int r = 3; r < 8; r++) begin
         wr(OFF_CONTROL, {1'b0, r[2:0], 4'h6});
         wait_irq();
         chk("half", n[7:0], 8'(1 << (9 - r)));
         rd(OFF_CONTROL);
         chk("pend", rv, {1'b1, r[2:0], 4'h6});
         wr(OFF_CONTROL, {1'b0, r[2:0], 4'h6});
         ci("no ack", 1'b1);
         wr(OFF_CONTROL, {1'b0, r[2:0], 4'hE});
         ci("ack", 1'b0);
         wait_irq();
         chk("full", n[7:0], 8'(1 << (10 - r)));
         wr(OFF_CONTROL, {1'b0, r[2:0], 4'h8});
      end
      wr(OFF_CONTROL, 8'h76);
      ticks(2);
      wr(OFF_CONTROL, 8'h74);
      wr(OFF_CONTROL, 8'h76);
      wait_irq();
      chk("restart", n[7:0], 8'h04);
      @(posedge mclk) wm <= 1'b1;
      wr(OFF_CONTROL, 8'h7E);
      rd(OFF_CONTROL);
      chk("wait rd", rv, 8'h00);
      ci("wait ack", 1'b1);
      ticks(8);
      @(posedge mclk) wm <= 1'b0;
      rd(OFF_STATUS);
      chk("overrun", rv, 8'h03);
      wr(OFF_CONTROL, 8'h70);
      ci("masked", 1'b0);
      wr(OFF_MASK, 8'h02);
      ci("ovr irq", 1'b1);
      wr(OFF_STATUS, 8'h03);
      rd(OFF_STATUS);
      chk("w1c", rv, 8'h00);
      ci("cleared", 1'b0);
      wr(2'h3, 8'hFF);
      rd(2'h3);
      chk("unmapped", rv, 8'h00);
      wr(OFF_CONTROL, 8'h76);
      @(posedge mclk) sm <= 1'b1;
      ticks(12);
      ci("frozen", 1'b0);
      @(posedge mclk) sm <= 1'b0;
      wait_irq();
      chk("resume", n[7:0], 8'h04);
      wr(OFF_CONTROL, 8'h7C);
      wr(OFF_CONTROL, 8'h76);
      @(posedge mclk) begin
         sm <= 1'b1;
         osc <= 1'b1;
      end
      wait_irq();
      chk("stop run", n[7:0], 8'h04);
      @(posedge mclk) sm <= 1'b0;
      wr(OFF_CONTROL, 8'h78);
      @(posedge mclk) wm <= 1'b1;
      ticks(8);
      @(posedge mclk) wm <= 1'b0;
      rd(OFF_CONTROL);
      chk("wait off", rv, 8'h70);
      conclude();
   end
endmodule // tb_top
